// *** verilog/sarc_map.svh ***
// Register offsets, field positions, reset values and counts
// for the start-up and readback controller. Definitions only.
`ifndef SARC_MAP_SVH
`define SARC_MAP_SVH

`define SARC_ADDR_W        12
`define SARC_OFS_CTRL      12'h000
`define SARC_OFS_TIMING    12'h004
`define SARC_OFS_STATUS    12'h008
`define SARC_OFS_MEM_ADDR  12'h00C
`define SARC_OFS_MEM_DATA  12'h010

`define SARC_CTRL_CAPTURE  0
`define SARC_CTRL_ABORT    1
`define SARC_CTRL_USER_CLK 2
`define SARC_CTRL_RB_EN    3
`define SARC_CTRL_GO       4

`define SARC_TIM_DONE_LSB  0
`define SARC_TIM_GSR_LSB   2
`define SARC_TIM_IO_LSB    4

`define SARC_ST_RIP        0
`define SARC_ST_DONE       1
`define SARC_ST_GSR_REL    2
`define SARC_ST_IO_ON      3

`define SARC_CTRL_RESET    4'h0
`define SARC_TIMING_RESET  6'h00

`define SARC_FRAME_BITS    16
`define SARC_FRAMES        8
`define SARC_FRAME_AW      3
`define SARC_LAST_FRAME    3'h7
`define SARC_LAST_BIT      5'h0F
`define SARC_LOAD_LAST     5'h05
`define SARC_CRC_LAST      5'h0A
`define SARC_CAP_BITS      7
`define SARC_CRC_POLY      16'h1021
`define SARC_CRC_INIT      16'hFFFF
`define SARC_SU_LAST       2'h3

`endif

// *** verilog/sarc_pkg.sv ***
// Types shared by the start-up and readback controller files.
// Assumes sarc_map.svh is on the include path.
`include "sarc_map.svh"

package sarc_pkg;

    typedef enum logic [2:0] {
        RB_IDLE  = 3'b000,
        RB_LOAD  = 3'b001,
        RB_START = 3'b010,
        RB_DATA  = 3'b011,
        RB_CRC   = 3'b100
    } sarc_rb_state_e;

    typedef struct packed {
        logic [3:0] cell_out;
        logic       io_out_ff;
        logic       io_input_first;
        logic       io_input_second;
    } sarc_capture_s;

    typedef struct packed {
        logic rb_enable;
        logic user_clk_sel;
        logic abort_en;
        logic capture_en;
    } sarc_opt_s;

endpackage

// *** verilog/sarc_frame_mem.sv ***
// Configuration frame store: write port on the bus clock,
// registered read port on the readback clock.
// Assumes contents stay still while a readback runs.
`timescale 1ns/1ps
`default_nettype none
`include "sarc_map.svh"

module sarc_frame_mem
    import sarc_pkg::*;
(
    input  wire logic                       wclk,
    input  wire logic                       we,
    input  wire logic [`SARC_FRAME_AW-1:0]  waddr,
    input  wire logic [`SARC_FRAME_BITS-1:0] wdata,
    input  wire logic                       rclk,
    input  wire logic [`SARC_FRAME_AW-1:0]  raddr,
    output logic      [`SARC_FRAME_BITS-1:0] rdata
);

    logic [`SARC_FRAME_BITS-1:0] mem [`SARC_FRAMES];

    always_ff @(posedge wclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge rclk) begin
        rdata <= mem[raddr];
    end

endmodule

`default_nettype wire

// *** verilog/sarc_top.sv ***
// Start-up sequencer and readback engine with an APB register port.
// Assumes APB master on pclk; readback runs on the selected link clock.
// Operation
// - Done, reset release, I/O enable any order
// - Events one period apart or together; the slots here allow up to three periods apart
// - Trigger rise captures inverted cell/io values
// - Configuration true, captured values inverted
// - No capture: stored values sent instead
// - Cell RAM writes overwrite frame contents
// - Trigger fall aborts and re-arms when enabled
// - In-progress flag high throughout readback
// - Configuration clock or user clock selectable
// - Readback state moves on rising edges
// - Unconnected controls make readback impossible
// - Frame loaded during six cycles before start
// - Stream ends with eleven CRC-16 MSBs
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sarc_map.svh"

module sarc_top
    import sarc_pkg::*;
(
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        clock_enable,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [`SARC_ADDR_W-1:0]     paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        configuration_clock,
    input  wire logic                        readback_user_clock,
    input  wire logic                        readback_trigger,
    input  wire sarc_capture_s               capture_in,
    input  wire logic                        cell_ram_we,
    input  wire logic [`SARC_FRAME_AW-1:0]   cell_ram_addr,
    input  wire logic [`SARC_FRAME_BITS-1:0] cell_ram_data,
    output logic                             readback_data,
    output logic                             readback_in_progress,
    output logic                             startup_done,
    output logic                             global_set_reset,
    output logic                             user_io_enable
);

    // ---------------- Bus clock domain ----------------
    sarc_opt_s                    opt;
    logic [1:0]                   slot_done;
    logic [1:0]                   slot_gsr;
    logic [1:0]                   slot_io;
    logic [`SARC_FRAME_AW-1:0]    mem_addr;
    logic                         su_run;
    logic [1:0]                   su_step;
    logic [1:0]                   rip_sync;
    logic                         wr_take;
    logic                         addr_ok;
    logic [31:0]                  rd_mux;
    logic                         go_pulse;
    logic                         mem_we;
    logic [`SARC_FRAME_AW-1:0]    mem_waddr;
    logic [`SARC_FRAME_BITS-1:0]  mem_wdata;

    assign wr_take  = psel & penable & pready & pwrite;
    assign go_pulse = wr_take && (paddr == `SARC_OFS_CTRL)
                      && pwdata[`SARC_CTRL_GO];

    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = 32'h0000_0000;
        unique case (paddr)
            `SARC_OFS_CTRL:     rd_mux[3:0] = opt;
            `SARC_OFS_TIMING:   rd_mux[5:0] = {slot_io, slot_gsr, slot_done};
            `SARC_OFS_STATUS: begin
                rd_mux[`SARC_ST_RIP]     = rip_sync[1];
                rd_mux[`SARC_ST_DONE]    = startup_done;
                rd_mux[`SARC_ST_GSR_REL] = ~global_set_reset;
                rd_mux[`SARC_ST_IO_ON]   = user_io_enable;
            end
            `SARC_OFS_MEM_ADDR: rd_mux[`SARC_FRAME_AW-1:0] = mem_addr;
            `SARC_OFS_MEM_DATA: rd_mux = 32'h0000_0000;
            default:            addr_ok = 1'b0;
        endcase
    end

    // Zero-wait slave: answer prepared in setup, pready in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clock_enable) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                pready  <= 1'b1;
                pslverr <= ~addr_ok;
                prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opt       <= `SARC_CTRL_RESET;
            slot_done <= 2'h0;
            slot_gsr  <= 2'h0;
            slot_io   <= 2'h0;
            mem_addr  <= '0;
        end else if (clock_enable && wr_take) begin
            unique case (paddr)
                `SARC_OFS_CTRL:     opt <= pwdata[3:0];
                `SARC_OFS_TIMING: begin
                    slot_done <= pwdata[`SARC_TIM_DONE_LSB +: 2];
                    slot_gsr  <= pwdata[`SARC_TIM_GSR_LSB +: 2];
                    slot_io   <= pwdata[`SARC_TIM_IO_LSB +: 2];
                end
                `SARC_OFS_MEM_ADDR:
                    mem_addr <= pwdata[`SARC_FRAME_AW-1:0];
                default: ;
            endcase
        end
    end

    // Each event fires at its own step; equal slots fire together
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            su_run           <= 1'b0;
            su_step          <= 2'h0;
            startup_done     <= 1'b0;
            global_set_reset <= 1'b1;
            user_io_enable   <= 1'b0;
        end else if (clock_enable) begin
            if (go_pulse && !su_run) begin
                su_run  <= 1'b1;
                su_step <= 2'h0;
            end else if (su_run) begin
                if (su_step != `SARC_SU_LAST) begin
                    su_step <= su_step + 2'h1;
                end
                if (su_step >= slot_done) begin
                    startup_done <= 1'b1;
                end
                if (su_step >= slot_gsr) begin
                    global_set_reset <= 1'b0;
                end
                if (su_step >= slot_io) begin
                    user_io_enable <= 1'b1;
                end
            end
        end
    end

    // Cell RAM writes win over bus writes to the same store
    always_comb begin
        mem_we    = 1'b0;
        mem_waddr = mem_addr;
        mem_wdata = pwdata[`SARC_FRAME_BITS-1:0];
        if (clock_enable && cell_ram_we) begin
            mem_we    = 1'b1;
            mem_waddr = cell_ram_addr;
            mem_wdata = cell_ram_data;
        end else if (clock_enable && wr_take
                     && paddr == `SARC_OFS_MEM_DATA) begin
            mem_we = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rip_sync <= 2'b00;
        end else if (clock_enable) begin
            rip_sync <= {rip_sync[0], readback_in_progress};
        end
    end

    // ---------------- Readback clock domain ----------------
    // Select is a static option; change it only while idle
    logic rb_clk;
    assign rb_clk = opt.user_clk_sel ? readback_user_clock
                                     : configuration_clock;

    logic [1:0]                   rb_rst_q;
    logic                         rb_rst_n;
    logic [3:0]                   opt_s1;
    logic [3:0]                   opt_s2;
    sarc_opt_s                    rb_opt;
    logic                         trig_s1;
    logic                         trig_s2;
    logic                         trig_d;
    logic                         trig_rise;
    logic                         trig_fall;
    logic [`SARC_CAP_BITS-1:0]    cap_s1;
    logic [`SARC_CAP_BITS-1:0]    cap_s2;
    logic [`SARC_CAP_BITS-1:0]    cap_q;
    sarc_rb_state_e               rb_state;
    logic [`SARC_FRAME_AW-1:0]    frame_idx;
    logic [4:0]                   bit_cnt;
    logic [`SARC_FRAME_BITS-1:0]  shift_q;
    logic [`SARC_FRAME_BITS-1:0]  mem_rdata;
    logic [`SARC_FRAME_BITS-1:0]  frame_word;
    logic [15:0]                  crc_q;

    always_ff @(posedge rb_clk or negedge presetn) begin
        if (!presetn) begin
            rb_rst_q <= 2'b00;
        end else begin
            rb_rst_q <= {rb_rst_q[0], 1'b1};
        end
    end
    assign rb_rst_n = rb_rst_q[1];

    // Options, trigger and capture pins pass two flops first
    always_ff @(posedge rb_clk or negedge rb_rst_n) begin
        if (!rb_rst_n) begin
            opt_s1  <= 4'h0;
            opt_s2  <= 4'h0;
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_d  <= 1'b0;
            cap_s1  <= '0;
            cap_s2  <= '0;
        end else begin
            opt_s1  <= opt;
            opt_s2  <= opt_s1;
            trig_s1 <= readback_trigger;
            trig_s2 <= trig_s1;
            trig_d  <= trig_s2;
            cap_s1  <= capture_in;
            cap_s2  <= cap_s1;
        end
    end

    assign rb_opt    = opt_s2;
    assign trig_rise = trig_s2 & ~trig_d;
    assign trig_fall = ~trig_s2 & trig_d;

    always_ff @(posedge rb_clk or negedge rb_rst_n) begin
        if (!rb_rst_n) begin
            cap_q <= '0;
        end else if (rb_opt.capture_en && trig_rise) begin
            cap_q <= ~cap_s2;
        end
    end

    // Capture bits occupy the low bits of frame zero
    always_comb begin
        frame_word = mem_rdata;
        if (rb_opt.capture_en && frame_idx == '0) begin
            frame_word[`SARC_CAP_BITS-1:0] = cap_q;
        end
    end

    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic        b);
        logic fb;
        fb = c[15] ^ b;
        crc_step = {c[14:0], 1'b0} ^ (fb ? `SARC_CRC_POLY : 16'h0000);
    endfunction

    sarc_frame_mem u_mem (
        .wclk  (pclk),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .rclk  (rb_clk),
        .raddr (frame_idx),
        .rdata (mem_rdata)
    );

    always_ff @(posedge rb_clk or negedge rb_rst_n) begin
        if (!rb_rst_n) begin
            rb_state             <= RB_IDLE;
            frame_idx            <= '0;
            bit_cnt              <= 5'h00;
            shift_q              <= '0;
            crc_q                <= `SARC_CRC_INIT;
            readback_data        <= 1'b1;
            readback_in_progress <= 1'b0;
        end else if (rb_state != RB_IDLE && rb_opt.abort_en
                     && trig_fall) begin
            rb_state             <= RB_IDLE;
            readback_in_progress <= 1'b0;
            readback_data        <= 1'b1;
        end else begin
            unique case (rb_state)
                RB_IDLE: begin
                    readback_data <= 1'b1;
                    if (trig_rise && rb_opt.rb_enable) begin
                        rb_state             <= RB_LOAD;
                        frame_idx            <= '0;
                        bit_cnt              <= 5'h00;
                        crc_q                <= `SARC_CRC_INIT;
                        readback_in_progress <= 1'b1;
                    end
                end
                RB_LOAD: begin
                    readback_data <= 1'b1;
                    bit_cnt       <= bit_cnt + 5'h01;
                    if (bit_cnt == `SARC_LOAD_LAST) begin
                        shift_q  <= frame_word;
                        bit_cnt  <= 5'h00;
                        rb_state <= RB_START;
                    end
                end
                RB_START: begin
                    readback_data <= 1'b0;
                    rb_state      <= RB_DATA;
                end
                RB_DATA: begin
                    readback_data <= shift_q[`SARC_FRAME_BITS-1];
                    shift_q       <= {shift_q[`SARC_FRAME_BITS-2:0], 1'b1};
                    crc_q <= crc_step(crc_q, shift_q[`SARC_FRAME_BITS-1]);
                    bit_cnt       <= bit_cnt + 5'h01;
                    if (bit_cnt == `SARC_LAST_BIT) begin
                        bit_cnt <= 5'h00;
                        if (frame_idx == `SARC_LAST_FRAME) begin
                            rb_state <= RB_CRC;
                        end else begin
                            frame_idx <= frame_idx + 3'h1;
                            rb_state  <= RB_LOAD;
                        end
                    end
                end
                RB_CRC: begin
                    bit_cnt <= bit_cnt + 5'h01;
                    // Flag drops only after the last check bit has stood
                    if (bit_cnt > `SARC_CRC_LAST) begin
                        rb_state             <= RB_IDLE;
                        readback_in_progress <= 1'b0;
                        readback_data        <= 1'b1;
                    end else begin
                        readback_data <= crc_q[4'hF - bit_cnt[3:0]];
                    end
                end
                default: begin
                    rb_state             <= RB_IDLE;
                    readback_in_progress <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// *** dv/sarc_top_checker.sv ***
// Port-level assertions for the start-up and readback controller.
// Assumes bind to sarc_top; readback checks use configuration_clock.
`timescale 1ns/1ps
`default_nettype none

module sarc_top_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clock_enable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic configuration_clock,
    input wire logic readback_data,
    input wire logic readback_in_progress,
    input wire logic startup_done,
    input wire logic global_set_reset,
    input wire logic user_io_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence all_on_s;
        startup_done && !global_set_reset && user_io_enable;
    endsequence

    apb_answer_a: assert property (psel && !penable && clock_enable |=> pready)
        else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    done_hold_a: assert property (startup_done |=> startup_done)
        else $error("done dropped");
    gsr_hold_a: assert property (!global_set_reset |=> !global_set_reset)
        else $error("set reset returned");
    io_hold_a: assert property (user_io_enable |=> user_io_enable)
        else $error("io enable dropped");
    event_span_a: assert property (($rose(startup_done) ||
        $fell(global_set_reset) || $rose(user_io_enable)) |-> ##[0:3] all_on_s)
        else $error("start-up events spread too far");
    load_ones_a: assert property (@(posedge configuration_clock)
        disable iff (!presetn) $rose(readback_in_progress) |-> readback_data)
        else $error("data low at readback start");
    idle_high_a: assert property (@(posedge configuration_clock)
        disable iff (!presetn)
        !readback_in_progress && !$past(readback_in_progress) |-> readback_data)
        else $error("data moving while idle");
endmodule

bind sarc_top sarc_top_checker checker_i (
    .pclk(pclk), .presetn(presetn), .clock_enable(clock_enable),
    .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
    .configuration_clock(configuration_clock), .readback_data(readback_data),
    .readback_in_progress(readback_in_progress), .startup_done(startup_done),
    .global_set_reset(global_set_reset), .user_io_enable(user_io_enable)
);

`default_nettype wire

// *** dv/sarc_rb_host.sv ***
// Behavioural readback master: trigger, user clock, bit capture.
// Assumes it faces sarc_top; user clock runs only during a transfer.
`timescale 1ns/1ps
`default_nettype none

module sarc_rb_host (
    input  wire logic configuration_clock,
    input  wire logic readback_data,
    input  wire logic readback_in_progress,
    output logic      readback_user_clock,
    output logic      readback_trigger
);
    logic run_clk  = 1'b0;
    logic use_user = 1'b0;
    logic bits [0:255];
    int   n = 0;
    wire  rclk = use_user ? readback_user_clock : configuration_clock;

    // Odd start offset keeps it unrelated to the bus clock
    initial begin
        readback_user_clock = 1'b0;
        readback_trigger = 1'b0;
        #3.3;
        forever #6 readback_user_clock = run_clk ^ readback_user_clock;
    end

    task run(input logic usr, input int abort_at);
        int k;
        k = 0;
        use_user = usr;
        run_clk = usr;
        n = 0;
        repeat (4) @(posedge rclk);
        readback_trigger <= 1'b1;
        while (readback_in_progress !== 1'b1 && k < 20) begin
            @(posedge rclk);
            k++;
        end
        // Bit count doubles as the abort position
        while (readback_in_progress === 1'b1 && n < 256 && n != abort_at) begin
            bits[n] = readback_data;
            n++;
            @(posedge rclk);
        end
        readback_trigger <= 1'b0;
        repeat (8) @(posedge rclk);
        run_clk = 1'b0;
    endtask
endmodule

`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench: APB register tasks and readback runs.
// Assumes sarc_top with configuration_clock tied to pclk.
`timescale 1ns/1ps
`default_nettype none
`include "sarc_map.svh"

module tb;
    import sarc_pkg::*;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic          cell_ram_we = 1'b0;
    logic [11:0]   paddr = 12'h000;
    logic [31:0]   pwdata = 32'h0000_0000, prdata, rd;
    logic          pready, pslverr, er, trig, uclk, rb_data, rip;
    logic          done, gsr, ioen;
    logic [2:0]    cell_ram_addr = 3'h0;
    logic [15:0]   cell_ram_data = 16'h0000;
    logic [15:0]   fm [0:7];
    sarc_capture_s cap = 7'h00;
    int            n_errors = 0, check_count = 0;

    always #20 pclk = ~pclk;

    sarc_top dut (
        .pclk(pclk), .presetn(presetn), .clock_enable(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .configuration_clock(pclk), .readback_user_clock(uclk),
        .readback_trigger(trig), .capture_in(cap), .cell_ram_we(cell_ram_we),
        .cell_ram_addr(cell_ram_addr), .cell_ram_data(cell_ram_data),
        .readback_data(rb_data), .readback_in_progress(rip),
        .startup_done(done), .global_set_reset(gsr), .user_io_enable(ioen)
    );

    sarc_rb_host host (
        .configuration_clock(pclk), .readback_data(rb_data),
        .readback_in_progress(rip), .readback_user_clock(uclk),
        .readback_trigger(trig)
    );

    task chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never re-drives psel at once
        @(posedge pclk);
    endtask

    task automatic cmp_stream(input logic cap_en, input logic [6:0] cv);
        logic [15:0] w, crc;
        logic        e[$];
        int          s;
        crc = 16'hFFFF;
        for (int f = 0; f < 8; f++) begin
            w = fm[f];
            if (f == 0 && cap_en) w[6:0] = ~cv;
            if (f > 0) repeat (6) e.push_back(1'b1);
            e.push_back(1'b0);
            for (int b = 15; b >= 0; b--) begin
                e.push_back(w[b]);
                crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ w[b]) ? 16'h1021 : 16'h0000);
            end
        end
        for (int b = 15; b >= 5; b--) e.push_back(crc[b]);
        s = 0;
        while (s < host.n && host.bits[s] === 1'b1) s++;
        for (int i = 0; i < e.size(); i++) chk({31'h0, host.bits[s+i]}, {31'h0, e[i]});
        chk(host.n, s + e.size());
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b1, `SARC_OFS_TIMING, 32'h0000_0012);
        apb(1'b1, `SARC_OFS_CTRL, 32'h0000_0018);
        // Slot s event is seen k >= s edges after the GO write returns
        for (int k = 0; k < 5; k++) begin
            @(negedge pclk);
            chk({29'h0, done, ~gsr, ioen}, {29'h0, k >= 2, 1'b1, k >= 1});
            @(posedge pclk);
        end
        @(posedge pclk);
        apb(1'b0, `SARC_OFS_CTRL, 32'h0000_0000);
        chk(rd, 32'h0000_0008);
        apb(1'b0, `SARC_OFS_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_000E);
        apb(1'b0, 12'h020, 32'h0000_0000);
        chk({rd[30:0], er}, 32'h0000_0001);
        $display("test startup done");
        for (int f = 0; f < 8; f++) begin
            fm[f] = 16'hC3A5 ^ (16'h0F11 * 16'(f));
            apb(1'b1, `SARC_OFS_MEM_ADDR, f);
            apb(1'b1, `SARC_OFS_MEM_DATA, {16'h0000, fm[f]});
        end
        cell_ram_we <= 1'b1;
        cell_ram_addr <= 3'h3;
        cell_ram_data <= 16'h5AA5;
        cap <= 7'h35;
        @(posedge pclk);
        cell_ram_we <= 1'b0;
        fm[3] = 16'h5AA5;
        host.run(1'b0, 999);
        cmp_stream(1'b0, 7'h35);
        apb(1'b1, `SARC_OFS_CTRL, 32'h0000_0009);
        host.run(1'b0, 999);
        cmp_stream(1'b1, 7'h35);
        $display("test readback done");
        apb(1'b1, `SARC_OFS_CTRL, 32'h0000_000E);
        host.run(1'b1, 40);
        chk({31'h0, rip}, 32'h0000_0000);
        host.run(1'b1, 999);
        cmp_stream(1'b0, 7'h35);
        $display("test abort done");
        @(posedge pclk);
        apb(1'b1, `SARC_OFS_CTRL, 32'h0000_0000);
        host.run(1'b0, 999);
        chk(host.n, 32'h0000_0000);
        $display("test disabled done");
        test_done;
    end

    initial begin
        #200_000;
        n_errors++;
        test_done;
    end
endmodule

`default_nettype wire
